// [common/pmd_pkg.sv]
// Package for the peripheral-processor microword field decoder: fields, codes, registers, types
package pmd_pkg;
    // Microword geometry
    localparam int WORD_W = 88;
    localparam int BR_ADDR_W = 10;
    // Field positions, word bit 0 is the first bit of the word
    localparam int A_ADD_LO = 8;
    localparam int A_ADD_HI = 12;
    localparam int Q_ADD_LO = 13;
    localparam int Q_ADD_HI = 14;
    localparam int P_DEC_BIT = 17;
    localparam int A_SEL_LO = 24;
    localparam int A_SEL_HI = 26;
    localparam int Q_SEL_LO = 27;
    localparam int Q_SEL_HI = 29;
    localparam int P_SEL_LO = 30;
    localparam int P_SEL_HI = 33;
    localparam int G_SEL_LO = 34;
    localparam int G_SEL_HI = 37;
    localparam int EXIT_LO = 38;
    localparam int EXIT_HI = 40;
    localparam int WR_LO = 41;
    localparam int WR_HI = 43;
    localparam int BR_LO = 44;
    localparam int BR_HI = 48;
    localparam int BR1_LO = 49;
    localparam int BR1_HI = 58;
    localparam int Y_LO = 59;
    localparam int Y_HI = 60;
    localparam int BR2_LO = 61;
    localparam int BR2_HI = 70;
    localparam int SUB_LO = 73;
    localparam int SUB_HI = 75;
    localparam int RD_EN_BIT = 76;
    localparam int WR_EN_BIT = 77;
    localparam int FF_EN_BIT = 78;
    localparam int PAR_BIT = 86;
    // APB register map
    localparam int APB_ADDR_W = 12;
    localparam logic [APB_ADDR_W-1:0] CTRL_OFF = 12'h000;
    localparam logic [APB_ADDR_W-1:0] STAT_OFF = 12'h004;
    localparam int CTRL_PCHK_BIT = 0;
    localparam logic CTRL_PCHK_RST = 1'b1;
    localparam int STAT_PERR_BIT = 0;
    localparam int STAT_SEL_LO = 4;
    localparam int STAT_ADDR_LO = 16;

    typedef enum logic [3:0] {
        A_OP_PASS_A = 4'b0000,
        A_OP_AND = 4'b0001,
        A_OP_PASS_B = 4'b0010,
        A_OP_ANDN = 4'b0011,
        A_OP_XOR = 4'b0100,
        A_OP_INV_B = 4'b0101,
        A_OP_SUB = 4'b0110,
        A_OP_ADD = 4'b0111,
        A_OP_NONE = 4'b1000
    } pmd_a_op_t;

    typedef enum logic [1:0] {
        Q_OP_ADD = 2'b00,
        Q_OP_LOAD = 2'b01,
        Q_OP_SUB = 2'b10,
        Q_OP_KEY = 2'b11
    } pmd_q_op_t;

    typedef enum logic [1:0] {
        NXT_FALL = 2'b00,
        NXT_BR1 = 2'b01,
        NXT_BR2 = 2'b10
    } pmd_next_t;

    typedef enum logic [1:0] {
        SUB_NONE = 2'b00,
        SUB_READ = 2'b01,
        SUB_WRITE = 2'b10,
        SUB_FUNC = 2'b11
    } pmd_sub_mode_t;

    // Status gathered from the channel, memory and access-unit logic
    typedef struct packed {
        logic data_store_full;
        logic chan_full;
        logic data_store_seq_active;
        logic chan_active;
        logic access_unit_busy;
        logic central_memory_busy;
        logic outstanding_req;
        logic data_ready;
        logic pp_error;
        logic exch_resp;
        logic exch_busy;
        logic chan_error;
        logic chan_flag;
        logic long_deadstart;
        logic exit_present;
        logic qreg_bit_fiftyeight_sel;
    } pmd_status_t;

    // Decoded control word handed to the datapath
    typedef struct packed {
        pmd_a_op_t a_op;
        pmd_q_op_t q_op;
        logic p_decrement;
        logic a_select_cond;
        logic q_select_cond;
        logic p_select_cond;
        logic g_select_cond;
        logic exit_cond;
        logic pp_write_cond;
        logic no_branch;
        logic branch_two;
        pmd_next_t next_sel;
        logic [1:0] y_mux_select;
        logic [2:0] unit_channel_subcode;
        pmd_sub_mode_t subcode_mode;
    } pmd_dec_t;
endpackage : pmd_pkg

// [design/pmd_microword_field_decoder.sv]
// Microword field decoder with condition logic, sequencer select and APB control
//
// Operation
// - A adder field selects eight adder operations
// - Q adder field selects four Q operations
// - Bit 17 makes P adder decrement
// - Bit 86 parity excludes both branch addresses
// - A select codes 0-3,5-7 decoded
// - A select 4: memory busy, request outstanding
// - Q select condition codes decoded
// - P select codes 0-11,16,17 decoded
// - P select codes 12-14 decoded
// - G select codes 0-6,16,17 decoded
// - G select 11 empty/error; 10 complement
// - G select 12-15 inactive and flag tests
// - Exit condition codes 0-3 decoded
// - Exit codes 4-7 decoded
// - PP write codes 0,4-7 decoded
// - PP write codes 1-3 idle tests
// - Branch code gives no-branch and branch-two
// - Branch codes 0-2 busy tests
// - Branch codes 20-22 tests
// - Sub-code meaning follows read/write/function enables
// - Full is either full; empty neither
// - Active is either active; inactive complement
// - Y mux select routes four sources
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module pmd_microword_field_decoder #(
    parameter int DATA_W = 16,
    parameter bit PARITY_ODD = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pmd_pkg::APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [pmd_pkg::WORD_W-1:0] micro_word,
    input wire logic [pmd_pkg::BR_ADDR_W-1:0] cur_addr,
    input wire pmd_pkg::pmd_status_t status,
    input wire logic [DATA_W-1:0] a_val,
    input wire logic [DATA_W-1:0] q_val,
    input wire logic [DATA_W-1:0] d_val,
    input wire logic [DATA_W-1:0] a_bypass_data,
    input wire logic [DATA_W-1:0] mac_data,
    input wire logic [DATA_W-1:0] chan_data,
    input wire logic [DATA_W-1:0] p_rank_data,
    output var pmd_pkg::pmd_dec_t dec,
    output logic [pmd_pkg::BR_ADDR_W-1:0] next_addr,
    output logic [DATA_W-1:0] y_data,
    output logic parity_err
);
    import pmd_pkg::*;

    // Derived status terms
    logic full, empty, active, inactive, q58;
    logic a_zero, a_one, a_neg, q_zero, q_lt3, d_zero;
    logic access_unit, cm;
    logic par_fault;
    pmd_dec_t dec_r, dec_nxt;
    logic [BR_ADDR_W-1:0] next_addr_r, next_addr_nxt;
    logic [DATA_W-1:0] y_data_r, y_data_nxt;
    logic parity_err_r, parity_err_nxt;
    logic ctrl_pchk_r, ctrl_pchk_nxt;
    logic perr_sticky_r, perr_sticky_nxt;
    logic [31:0] prdata_r, prdata_nxt, rd_word;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic apb_done, addr_ok, stat_clr;
    logic [4:0] a_code, br_code;
    logic [3:0] p_code, g_code;
    logic [2:0] as_code, qs_code, ex_code, wr_code;

    // Parity over the word with both branch address fields masked out
    function automatic logic par_calc(input logic [WORD_W-1:0] w);
        logic p;
        p = 1'b0;
        for (int i = 0; i < WORD_W; i++) begin
            if (!((i >= BR1_LO && i <= BR1_HI) || (i >= BR2_LO && i <= BR2_HI))) begin
                p = p ^ w[i];
            end
        end
        return p;
    endfunction : par_calc

    // Channel status combinations shared by many conditions
    assign full = status.data_store_full | status.chan_full;
    assign empty = ~status.data_store_full & ~status.chan_full;
    assign active = status.data_store_seq_active | status.chan_active;
    assign inactive = ~active;
    assign q58 = status.qreg_bit_fiftyeight_sel;
    assign access_unit = status.access_unit_busy;
    assign cm = status.central_memory_busy;
    assign a_zero = (a_val == '0);
    assign a_one = (a_val == DATA_W'(1));
    assign a_neg = a_val[DATA_W-1];
    assign q_zero = (q_val == '0);
    assign q_lt3 = (q_val < DATA_W'(3));
    assign d_zero = (d_val == '0);
    assign par_fault = (par_calc(micro_word) != PARITY_ODD);

    // Field extraction, the store is trusted to hold the word steady
    assign a_code = micro_word[A_ADD_HI:A_ADD_LO];
    assign as_code = micro_word[A_SEL_HI:A_SEL_LO];
    assign qs_code = micro_word[Q_SEL_HI:Q_SEL_LO];
    assign p_code = micro_word[P_SEL_HI:P_SEL_LO];
    assign g_code = micro_word[G_SEL_HI:G_SEL_LO];
    assign ex_code = micro_word[EXIT_HI:EXIT_LO];
    assign wr_code = micro_word[WR_HI:WR_LO];
    assign br_code = micro_word[BR_HI:BR_LO];

    // Field decode; case labels are hex forms of the octal codes
    always_comb begin
        dec_nxt = '0;
        case (a_code)
            5'h00: dec_nxt.a_op = A_OP_PASS_A;
            5'h04: dec_nxt.a_op = A_OP_AND;
            5'h05: dec_nxt.a_op = A_OP_PASS_B;
            5'h08: dec_nxt.a_op = A_OP_ANDN;
            5'h09: dec_nxt.a_op = A_OP_XOR;
            5'h0A: dec_nxt.a_op = A_OP_INV_B;
            5'h16: dec_nxt.a_op = A_OP_SUB;
            5'h19: dec_nxt.a_op = A_OP_ADD;
            default: dec_nxt.a_op = A_OP_NONE;
        endcase
        dec_nxt.q_op = pmd_q_op_t'(micro_word[Q_ADD_HI:Q_ADD_LO]);
        dec_nxt.p_decrement = micro_word[P_DEC_BIT];
        case (as_code)
            3'h0: dec_nxt.a_select_cond = full | inactive;
            3'h1: dec_nxt.a_select_cond = empty;
            3'h2: dec_nxt.a_select_cond = access_unit;
            3'h3: dec_nxt.a_select_cond = cm;
            3'h4: dec_nxt.a_select_cond = cm & status.outstanding_req;
            3'h5: dec_nxt.a_select_cond = access_unit | cm;
            3'h6: dec_nxt.a_select_cond = 1'b0;
            default: dec_nxt.a_select_cond = 1'b1;
        endcase
        case (qs_code)
            3'h0: dec_nxt.q_select_cond = access_unit | ~status.data_ready;
            3'h1: dec_nxt.q_select_cond = access_unit;
            3'h2: dec_nxt.q_select_cond = q_zero | status.pp_error;
            3'h4: dec_nxt.q_select_cond = 1'b1;
            3'h6: dec_nxt.q_select_cond = 1'b1;
            default: dec_nxt.q_select_cond = 1'b0;
        endcase
        case (p_code)
            4'h4: dec_nxt.p_select_cond = access_unit | ~status.data_ready;
            4'h5: dec_nxt.p_select_cond = access_unit;
            4'h6: dec_nxt.p_select_cond = access_unit | cm;
            4'h8: dec_nxt.p_select_cond = full | inactive;
            4'h9: dec_nxt.p_select_cond = active & empty;
            4'hA: dec_nxt.p_select_cond = active & empty & ~a_zero;
            4'hB: dec_nxt.p_select_cond = ~status.exch_resp;
            4'hC: dec_nxt.p_select_cond = active & ~q58;
            4'hD: dec_nxt.p_select_cond = 1'b0;
            4'hE: dec_nxt.p_select_cond = 1'b0;
            default: dec_nxt.p_select_cond = 1'b1;
        endcase
        case (g_code)
            4'h0: dec_nxt.g_select_cond = ~a_neg;
            4'h1: dec_nxt.g_select_cond = a_neg;
            4'h2: dec_nxt.g_select_cond = a_zero;
            4'h3: dec_nxt.g_select_cond = ~a_zero;
            4'h4: dec_nxt.g_select_cond = ~d_zero;
            4'h5: dec_nxt.g_select_cond = 1'b1;
            4'h6: dec_nxt.g_select_cond = access_unit | cm;
            4'h8: dec_nxt.g_select_cond = ~(empty & ~q58 | ~status.chan_error & q58);
            4'h9: dec_nxt.g_select_cond = empty & ~q58 | ~status.chan_error & q58;
            4'hA: dec_nxt.g_select_cond = ~(inactive & ~q58 | ~status.chan_flag & q58);
            4'hB: dec_nxt.g_select_cond = inactive & ~q58;
            4'hC: dec_nxt.g_select_cond = status.chan_flag;
            4'hD: dec_nxt.g_select_cond = ~status.chan_flag;
            4'hE: dec_nxt.g_select_cond = 1'b1;
            default: dec_nxt.g_select_cond = 1'b0;
        endcase
        case (ex_code)
            3'h0: dec_nxt.exit_cond = full | inactive & q58;
            3'h1: dec_nxt.exit_cond = active & empty | inactive & q58;
            3'h2: dec_nxt.exit_cond = active | q58;
            3'h3: dec_nxt.exit_cond = inactive | q58;
            3'h4: dec_nxt.exit_cond = status.exch_resp;
            3'h5: dec_nxt.exit_cond = ~(cm | access_unit);
            3'h6: dec_nxt.exit_cond = d_zero | status.exit_present;
            default: dec_nxt.exit_cond = 1'b0;
        endcase
        case (wr_code)
            3'h0: dec_nxt.pp_write_cond = full | inactive;
            3'h1: dec_nxt.pp_write_cond = ~access_unit;
            3'h2: dec_nxt.pp_write_cond = ~access_unit | ~cm;
            3'h3: dec_nxt.pp_write_cond = ~access_unit & status.data_ready;
            3'h4: dec_nxt.pp_write_cond = full | inactive | a_zero;
            3'h5: dec_nxt.pp_write_cond = status.long_deadstart;
            3'h6: dec_nxt.pp_write_cond = 1'b1;
            default: dec_nxt.pp_write_cond = 1'b0;
        endcase
        // A word with bad parity must not write PP memory when checking is on
        if (par_fault && ctrl_pchk_r) begin
            dec_nxt.pp_write_cond = 1'b0;
        end
        // Pair of branch tests per code: no-branch and branch-two
        case (br_code)
            5'h00: dec_nxt.branch_two = cm;
            5'h01: dec_nxt.branch_two = access_unit | ~status.data_ready;
            5'h02: dec_nxt.branch_two = access_unit | cm;
            5'h03: dec_nxt.branch_two = full & ~a_one | active & empty;
            5'h05: dec_nxt.branch_two = full | active & empty & ~a_one;
            5'h06: begin
                dec_nxt.no_branch = a_zero;
                dec_nxt.branch_two = active & empty & ~a_zero;
            end
            5'h07: begin
                dec_nxt.no_branch = full & ~a_zero & ~a_one;
                dec_nxt.branch_two = active & empty & ~a_zero;
            end
            5'h08: dec_nxt.no_branch = ~q_zero & ~status.pp_error;
            5'h09: begin
                dec_nxt.no_branch = inactive | a_one & active & empty;
                dec_nxt.branch_two = full;
            end
            5'h0A: begin
                dec_nxt.no_branch = active & empty & ~a_one;
                dec_nxt.branch_two = full;
            end
            5'h0B: dec_nxt.no_branch = a_zero;
            5'h0C: dec_nxt.no_branch = q_lt3;
            5'h0D: begin
                dec_nxt.no_branch = ~(q_zero | status.pp_error | cm | access_unit);
                dec_nxt.branch_two = cm | access_unit;
            end
            5'h0E, 5'h0F: begin
                dec_nxt.no_branch = 1'b1;
                dec_nxt.branch_two = 1'b1;
            end
            5'h10: dec_nxt.branch_two = access_unit;
            5'h11: dec_nxt.branch_two = 1'b1;
            5'h12: dec_nxt.branch_two = status.exch_busy | cm;
            default: dec_nxt.branch_two = 1'b0;
        endcase
        // No-branch wins so codes with both tests true fall through
        if (dec_nxt.no_branch) begin
            dec_nxt.next_sel = NXT_FALL;
        end else if (dec_nxt.branch_two) begin
            dec_nxt.next_sel = NXT_BR2;
        end else begin
            dec_nxt.next_sel = NXT_BR1;
        end
        dec_nxt.y_mux_select = micro_word[Y_HI:Y_LO];
        dec_nxt.unit_channel_subcode = micro_word[SUB_HI:SUB_LO];
        // Read enable outranks write, write outranks function-or-full
        if (micro_word[RD_EN_BIT]) begin
            dec_nxt.subcode_mode = SUB_READ;
        end else if (micro_word[WR_EN_BIT]) begin
            dec_nxt.subcode_mode = SUB_WRITE;
        end else if (micro_word[FF_EN_BIT]) begin
            dec_nxt.subcode_mode = SUB_FUNC;
        end else begin
            dec_nxt.subcode_mode = SUB_NONE;
        end
    end

    // Sequencer target and Y mux data
    always_comb begin
        case (dec_nxt.next_sel)
            NXT_FALL: next_addr_nxt = cur_addr + BR_ADDR_W'(1);
            NXT_BR2: next_addr_nxt = micro_word[BR2_HI:BR2_LO];
            default: next_addr_nxt = micro_word[BR1_HI:BR1_LO];
        endcase
        case (micro_word[Y_HI:Y_LO])
            2'h0: y_data_nxt = a_bypass_data;
            2'h1: y_data_nxt = mac_data;
            2'h2: y_data_nxt = chan_data;
            default: y_data_nxt = p_rank_data;
        endcase
        parity_err_nxt = par_fault;
    end

    // APB slave: one wait state, so pready and prdata both come from flops
    assign apb_done = psel & penable & pready_r;
    assign addr_ok = (paddr == CTRL_OFF) || (paddr == STAT_OFF);
    assign stat_clr = apb_done & pwrite & (paddr == STAT_OFF) & pwdata[STAT_PERR_BIT];

    always_comb begin
        rd_word = '0;
        if (paddr == CTRL_OFF) begin
            rd_word[CTRL_PCHK_BIT] = ctrl_pchk_r;
        end else if (paddr == STAT_OFF) begin
            rd_word[STAT_PERR_BIT] = perr_sticky_r;
            rd_word[STAT_SEL_LO +: 2] = dec_r.next_sel;
            rd_word[STAT_ADDR_LO +: BR_ADDR_W] = next_addr_r;
        end
        pready_nxt = psel & penable & ~pready_r;
        pslverr_nxt = pready_nxt & ~addr_ok;
        prdata_nxt = (pready_nxt & ~pwrite) ? rd_word : '0;
        ctrl_pchk_nxt = ctrl_pchk_r;
        if (apb_done && pwrite && paddr == CTRL_OFF) begin
            ctrl_pchk_nxt = pwdata[CTRL_PCHK_BIT];
        end
        // A new parity fault in the clearing cycle keeps the flag set
        perr_sticky_nxt = par_fault | (perr_sticky_r & ~stat_clr);
    end

    // All state registered here; asynchronous reset loads constants only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dec_r <= '0;
            next_addr_r <= '0;
            y_data_r <= '0;
            parity_err_r <= 1'b0;
            ctrl_pchk_r <= CTRL_PCHK_RST;
            perr_sticky_r <= 1'b0;
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            dec_r <= dec_nxt;
            next_addr_r <= next_addr_nxt;
            y_data_r <= y_data_nxt;
            parity_err_r <= parity_err_nxt;
            ctrl_pchk_r <= ctrl_pchk_nxt;
            perr_sticky_r <= perr_sticky_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign dec = dec_r;
    assign next_addr = next_addr_r;
    assign y_data = y_data_r;
    assign parity_err = parity_err_r;
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // Checks on the decoded outputs, one cycle after the word is presented
    sequence s_br_both;
        br_code == 5'h0E || br_code == 5'h0F;
    endsequence
    sequence s_br_fall;
        dec_r.next_sel == NXT_FALL && next_addr_r == $past(cur_addr) + BR_ADDR_W'(1);
    endsequence
    sequence s_br_two;
        br_code == 5'h11 && !(par_fault && ctrl_pchk_r);
    endsequence

    property p_a_add;
        @(posedge pclk) disable iff (!presetn)
        a_code == 5'h19 |=> dec_r.a_op == A_OP_ADD;
    endproperty
    a_a_add: assert property (p_a_add) else $error("A adder add code not decoded");

    property p_q_op;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> dec_r.q_op == pmd_q_op_t'($past(micro_word[Q_ADD_HI:Q_ADD_LO]));
    endproperty
    a_q_op: assert property (p_q_op) else $error("Q adder operation mismatch");

    property p_p_dec;
        @(posedge pclk) disable iff (!presetn)
        micro_word[P_DEC_BIT] ##1 !micro_word[P_DEC_BIT] |=> $fell(dec_r.p_decrement);
    endproperty
    a_p_dec: assert property (p_p_dec) else $error("P decrement does not follow word");

    property p_parity;
        @(posedge pclk) disable iff (!presetn)
        par_fault |=> parity_err_r && perr_sticky_r;
    endproperty
    a_parity: assert property (p_parity) else $error("Parity fault not flagged");

    property p_a_sel4;
        @(posedge pclk) disable iff (!presetn)
        as_code == 3'h4 && !(cm && status.outstanding_req) |=> !dec_r.a_select_cond;
    endproperty
    a_a_sel4: assert property (p_a_sel4) else $error("A select 4 true without cause");

    property p_full;
        @(posedge pclk) disable iff (!presetn)
        as_code == 3'h1 && status.chan_full |=> !dec_r.a_select_cond;
    endproperty
    a_full: assert property (p_full) else $error("Empty reported while channel full");

    property p_g_compl;
        @(posedge pclk) disable iff (!presetn)
        g_code == 4'h9 ##1 g_code == 4'h8 && $stable(status) && $stable(a_val)
            |=> dec_r.g_select_cond != $past(dec_r.g_select_cond);
    endproperty
    a_g_compl: assert property (p_g_compl) else $error("G select 10 not complement of 11");

    property p_exit7;
        @(posedge pclk) disable iff (!presetn)
        ex_code == 3'h7 |=> !dec_r.exit_cond;
    endproperty
    a_exit7: assert property (p_exit7) else $error("Exit code 7 not zero");

    property p_br_both;
        @(posedge pclk) disable iff (!presetn)
        s_br_both |=> s_br_fall;
    endproperty
    a_br_both: assert property (p_br_both) else $error("Both tests true did not fall through");

    property p_br_two;
        @(posedge pclk) disable iff (!presetn)
        s_br_two |=> dec_r.next_sel == NXT_BR2 && next_addr_r == $past(micro_word[BR2_HI:BR2_LO]);
    endproperty
    a_br_two: assert property (p_br_two) else $error("Branch code 21 did not take address 2");

    property p_y_chan;
        @(posedge pclk) disable iff (!presetn)
        micro_word[Y_HI:Y_LO] == 2'h2 |=> y_data_r == $past(chan_data);
    endproperty
    a_y_chan: assert property (p_y_chan) else $error("Y mux did not route channel data");
endmodule : pmd_microword_field_decoder
`default_nettype wire

// [dv/pmd_store_model.sv]
// Control store model: presents each word with its parity bit filled in
`timescale 1ns/10ps
`default_nettype none
module pmd_store_model (
    input wire logic [pmd_pkg::WORD_W-1:0] fields,
    input wire logic bad_par,
    output logic [pmd_pkg::WORD_W-1:0] micro_word
);
    import pmd_pkg::*;
    // Both branch addresses and the parity bit itself stay out of the sum
    localparam logic [WORD_W-1:0] PMASK = ~((88'h1 << 86) | (88'h3FF << 49) | (88'h3FF << 61));
    // Odd parity, inverted only when a scenario asks for a bad word
    always_comb begin
        micro_word = fields;
        micro_word[PAR_BIT] = ~bad_par ^ (^(fields & PMASK));
    end
endmodule : pmd_store_model
`default_nettype wire

// [dv/tb.sv]
// Bench: drives microwords, status and APB, checks decode results
`timescale 1ns/10ps
`default_nettype none
module tb;
    import pmd_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, bad = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic pready, pslverr, perr, e;
    logic [87:0] fields = '0, mw, w;
    logic [9:0] nxt;
    logic [15:0] a_val = 16'h0001, y;
    logic [15:0] src [4] = '{16'h1111, 16'h2222, 16'h3333, 16'h4444};
    logic [4:0] acode [9] = '{5'h00, 5'h04, 5'h05, 5'h08, 5'h09, 5'h0A, 5'h16, 5'h19, 5'h01};
    pmd_status_t status = '0, s;
    pmd_dec_t dec;
    int num_errors = 0, n_checks = 0, i;
    // Clock, 4 ns period
    always #2 pclk = ~pclk;
    pmd_store_model u_pmd_store_model (.fields(fields), .bad_par(bad), .micro_word(mw));
    pmd_microword_field_decoder u_pmd_microword_field_decoder (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .micro_word(mw),
        .cur_addr(10'h100), .status(status), .a_val(a_val), .q_val(16'h0002),
        .d_val(16'h0000), .a_bypass_data(src[0]), .mac_data(src[1]), .chan_data(src[2]),
        .p_rank_data(src[3]), .dec(dec), .next_addr(nxt), .y_data(y), .parity_err(perr));
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [87:0] f(input int lo, input logic [9:0] v);
        return 88'(v) << lo;
    endfunction : f
    // Word and status go in at one edge; decode is looked at after the next
    task automatic step(input logic [87:0] wd, input pmd_status_t st);
        @(posedge pclk);
        fields <= wd;
        status <= st;
        @(posedge pclk);
        #1;
    endtask : step
    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        r = prdata;
        e = pslverr;
        // A lost answer counts once; the run still ends in summarize
        if (k >= 20) begin
            num_errors++;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        s = '0;
        for (i = 0; i < 9; i++) begin
            step(f(A_ADD_LO, acode[i]), s);
            chk(dec.a_op, i);
        end
        for (i = 0; i < 4; i++) begin
            step(f(Q_ADD_LO, 10'(i)) | f(Y_LO, 10'(i)), s);
            chk(dec.q_op, i);
            chk(y, src[i]);
        end
        step(f(P_DEC_BIT, 1), s);
        chk(dec.p_decrement, 1);
        step(f(A_SEL_LO, 1), s);
        chk(dec.a_select_cond, 1);
        step(f(EXIT_LO, 5), s);
        chk(dec.exit_cond, 1);
        s.central_memory_busy = 1'b1;
        step(f(A_SEL_LO, 4) | f(EXIT_LO, 5), s);
        chk(dec.a_select_cond, 0);
        chk(dec.exit_cond, 0);
        s.outstanding_req = 1'b1;
        s.chan_full = 1'b1;
        step(f(A_SEL_LO, 4), s);
        chk(dec.a_select_cond, 1);
        step(f(A_SEL_LO, 1), s);
        chk(dec.a_select_cond, 0);
        s = '0;
        s.qreg_bit_fiftyeight_sel = 1'b1;
        s.chan_error = 1'b1;
        step(f(G_SEL_LO, 9), s);
        chk(dec.g_select_cond, 0);
        step(f(G_SEL_LO, 8), s);
        chk(dec.g_select_cond, 1);
        // Inactive and empty channel, selector set, nothing busy, data not ready
        w = f(P_SEL_LO, 4'hE) | f(EXIT_LO, 3) | f(G_SEL_LO, 4'hD);
        step(w, s);
        chk(dec.a_select_cond, 1);
        chk(dec.q_select_cond, 1);
        chk(dec.p_select_cond, 0);
        chk(dec.g_select_cond, 1);
        chk(dec.exit_cond, 1);
        chk(dec.pp_write_cond, 1);
        chk(dec.next_sel, NXT_BR1);
        w = f(P_SEL_LO, 4'hB) | f(EXIT_LO, 7) | f(WR_LO, 1) | f(BR_LO, 1) | f(Q_SEL_LO, 3);
        step(w | f(A_SEL_LO, 6) | f(SUB_LO, 5) | f(RD_EN_BIT, 1) | f(WR_EN_BIT, 1), s);
        chk(dec.a_select_cond, 0);
        chk(dec.q_select_cond, 0);
        chk(dec.p_select_cond, 1);
        chk(dec.g_select_cond, 1);
        chk(dec.exit_cond, 0);
        chk(dec.pp_write_cond, 1);
        chk(dec.next_sel, NXT_BR2);
        chk(dec.unit_channel_subcode, 5);
        chk(dec.subcode_mode, SUB_READ);
        // Fall through, branch two, branch one
        w = f(BR1_LO, 10'h2AA) | f(BR2_LO, 10'h155);
        step(w | f(BR_LO, 5'h0E), s);
        chk(nxt, 10'h101);
        step(w | f(BR_LO, 5'h11), s);
        chk(nxt, 10'h155);
        step(w | f(BR_LO, 5'h13), s);
        chk(nxt, 10'h2AA);
        step(f(WR_LO, 6), s);
        chk(dec.pp_write_cond, 1);
        chk(perr, 0);
        // The store changes its word only at a rising edge
        @(posedge pclk);
        bad <= 1'b1;
        step(f(WR_LO, 6), s);
        chk(dec.pp_write_cond, 0);
        chk(perr, 1);
        @(posedge pclk);
        bad <= 1'b0;
        // Registers: sticky error, clear, control reset value, unmapped place
        apb(1'b0, STAT_OFF, 32'h0);
        chk(r[0], 1);
        apb(1'b1, STAT_OFF, 32'h1);
        apb(1'b0, STAT_OFF, 32'h0);
        chk(r[0], 0);
        apb(1'b0, CTRL_OFF, 32'h0);
        chk(r, 32'(CTRL_PCHK_RST));
        apb(1'b0, 12'h008, 32'h0);
        chk(e, 1);
        chk(r, 32'h0);
        apb(1'b1, CTRL_OFF, 32'h0);
        bad <= 1'b1;
        step(f(WR_LO, 6), s);
        chk(dec.pp_write_cond, 1);
        summarize();
    end
endmodule : tb
`default_nettype wire
